// ===== rtl/amag_guard.sv
/*
 * area memory access guard: sits between the core and the rom, ram and
 * otp memories, checks every access inside an area against per-area permission words
 * and passes only permitted ones on; holds the area configuration.
 * assumes the core drives all inputs from mclk and that the memory side
 * takes an access in the cycle mem_valid is high.
 */
`timescale 1ns/1ns
module amag_guard (
	input wire logic mclk, // core clock
	input wire logic rst, // async reset, active high
	input wire logic cfg_valid, // configuration write strobe
	input wire logic cfg_priv, // writer runs in privileged mode
	input wire logic [amag_pkg::AREA_IDX_W-1:0] cfg_area, // target area
	input wire amag_pkg::amag_field_t cfg_field, // target word
	input wire logic [amag_pkg::ADDR_W-1:0] cfg_wdata, // value to write
	output logic cfg_refused, // pulse: write had no effect
	output logic locked, // rules finally accepted
	input wire logic req_valid, // core access request
	input wire logic req_priv, // access from privileged mode
	input wire amag_pkg::amag_op_t req_op, // read, write or execute
	input wire logic [amag_pkg::ADDR_W-1:0] req_addr, // target address
	input wire logic [amag_pkg::ADDR_W-1:0] req_src_addr, // issuing pc
	output logic mem_valid, // access passed to the memory
	output logic req_denied, // access blocked this cycle
	output logic fault, // pulse one cycle after a denial
	output logic [amag_pkg::ADDR_W-1:0] fault_addr, // last denied address
	output amag_pkg::amag_op_t fault_op // last denied operation
);
	import amag_pkg::*;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// address inside an inclusive area; base above limit disables it
	function automatic logic area_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] l);
		area_hit = (a >= b) && (a <= l);
	endfunction : area_hit

	// permission bit for an operation in a privilege level
	function automatic int perm_bit(input amag_op_t op, input logic pv);
		perm_bit = (pv ? PERM_PRIV_LSB : PERM_USER_LSB) + int'(op);
	endfunction : perm_bit

	// ------------------------------------------------------------------
	// configuration state
	// ------------------------------------------------------------------
	logic [ADDR_W-1:0] base [AREA_N]; // area lower bounds
	logic [ADDR_W-1:0] limit [AREA_N]; // area upper bounds
	logic [PERM_W-1:0] perm [AREA_N]; // area permission words
	logic [ADDR_W-1:0] next_base [AREA_N];
	logic [ADDR_W-1:0] next_limit [AREA_N];
	logic [PERM_W-1:0] next_perm [AREA_N];
	logic next_locked;
	logic next_cfg_refused;
	logic cfg_ok; // write is allowed to land

	// next values of the control words; user mode or a locked guard
	// leaves everything as it is and only reports the refusal
	always_comb begin
		cfg_ok = cfg_valid && cfg_priv && !locked;
		next_base = base;
		next_limit = limit;
		next_perm = perm;
		next_locked = locked;
		next_cfg_refused = cfg_valid && !cfg_ok;
		if (cfg_ok) begin
			case (cfg_field)
				AMAG_F_BASE: begin
					next_base[cfg_area] = cfg_wdata;
				end
				AMAG_F_LIMIT: begin
					next_limit[cfg_area] = cfg_wdata;
				end
				AMAG_F_PERM: begin
					next_perm[cfg_area] = cfg_wdata[PERM_W-1:0];
				end
				AMAG_F_LOCK: begin
					// lock is one-way until reset: final acceptance
					next_locked = next_locked | cfg_wdata[0];
				end
				default: begin
					next_locked = locked;
				end
			endcase
		end
	end

	// register the control words; defaults come back on every reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			base <= AREA_BASE_RST;
			limit <= AREA_LIMIT_RST;
			perm <= AREA_PERM_RST;
			locked <= LOCK_RST;
			cfg_refused <= 1'b0;
		end else begin
			base <= next_base;
			limit <= next_limit;
			perm <= next_perm;
			locked <= next_locked;
			cfg_refused <= next_cfg_refused;
		end
	end

	// ------------------------------------------------------------------
	// area match
	// ------------------------------------------------------------------
	logic [AREA_N-1:0] tgt_hit; // target address per area
	logic [AREA_N-1:0] src_hit; // issuing code address per area

	genvar gi;
	generate
		for (gi = 0; gi < AREA_N; gi++) begin : g_match
			assign tgt_hit[gi] = area_hit(req_addr, base[gi], limit[gi]);
			assign src_hit[gi] =
				area_hit(req_src_addr, base[gi], limit[gi]);
		end
	endgenerate

	// ------------------------------------------------------------------
	// permit decision, purely combinational so it acts before the access
	// ------------------------------------------------------------------
	logic allow; // access may proceed
	logic [PERM_W-1:0] tgt_perm; // permission word of the target area
	logic tgt_any; // target lies in a guarded area

	// lowest matching area wins where areas overlap; addresses outside
	// every area are not guarded memory and pass unchecked
	always_comb begin
		tgt_perm = '0;
		tgt_any = 1'b0;
		for (int k = AREA_N - 1; k >= 0; k--) begin
			if (tgt_hit[k]) begin
				tgt_perm = perm[k];
				tgt_any = 1'b1;
			end
		end
		allow = 1'b1;
		if (tgt_any) begin
			// op and privilege pick one bit
			allow = tgt_perm[perm_bit(req_op, req_priv)];
			// issuing code inside a guarded area must sit in an allowed source area
			if (|src_hit) begin
				allow = allow && |(src_hit & tgt_perm[PERM_W-1:PERM_SRC_LSB]);
			end
		end
	end

	// handshake outputs are combinational to add no latency
	assign mem_valid = req_valid && allow;
	assign req_denied = req_valid && !allow;

	// ------------------------------------------------------------------
	// fault report
	// ------------------------------------------------------------------
	logic next_fault;
	logic [ADDR_W-1:0] next_fault_addr;
	amag_op_t next_fault_op;

	// capture each denial; address and op hold until the next one
	always_comb begin
		next_fault = req_denied;
		next_fault_addr = fault_addr;
		next_fault_op = fault_op;
		if (req_denied) begin
			next_fault_addr = req_addr;
			next_fault_op = req_op;
		end
	end

	// fault registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fault <= 1'b0;
			fault_addr <= '0;
			fault_op <= AMAG_OP_READ;
		end else begin
			fault <= next_fault;
			fault_addr <= next_fault_addr;
			fault_op <= next_fault_op;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	// flat copies and default flags of the control words, so that checks
	// compare whole sets without relying on unpacked array operators
	logic [AREA_N*PERM_W-1:0] perm_flat; // all permission words
	logic [AREA_N*ADDR_W-1:0] base_flat; // all lower bounds
	logic [AREA_N*ADDR_W-1:0] limit_flat; // all upper bounds
	logic [AREA_N-1:0] at_dflt; // area still holds its reset words

	generate
		for (gi = 0; gi < AREA_N; gi++) begin : g_flat
			assign perm_flat[gi*PERM_W +: PERM_W] = perm[gi];
			assign base_flat[gi*ADDR_W +: ADDR_W] = base[gi];
			assign limit_flat[gi*ADDR_W +: ADDR_W] = limit[gi];
			assign at_dflt[gi] = (perm[gi] == AREA_PERM_RST[gi])
				&& (base[gi] == AREA_BASE_RST[gi])
				&& (limit[gi] == AREA_LIMIT_RST[gi]);
		end
	endgenerate

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	deny_blocks_a: assert property (req_denied |-> !mem_valid)
		else $error("denied access reached memory");
	fault_follows_a: assert property (
		req_denied |=> fault && fault_addr == $past(req_addr))
		else $error("denial not reported next cycle");
	user_cfg_a: assert property (
		cfg_valid && !cfg_priv |=> cfg_refused
			&& perm_flat == $past(perm_flat)
			&& base_flat == $past(base_flat)
			&& limit_flat == $past(limit_flat))
		else $error("user write changed the rules");
	lock_holds_a: assert property (locked |=> locked)
		else $error("lock released without reset");
	cfg_applied_a: assert property (
		cfg_ok && cfg_field == AMAG_F_PERM |=>
			perm[$past(cfg_area)] == $past(cfg_wdata[PERM_W-1:0]))
		else $error("permission write not applied");
	grant_bit_a: assert property (
		mem_valid && tgt_hit[0] |-> perm[0][perm_bit(req_op, req_priv)])
		else $error("access granted without permission bit");
	src_check_a: assert property (
		mem_valid && tgt_hit[0] && |src_hit |->
			|(src_hit & perm[0][PERM_W-1:PERM_SRC_LSB]))
		else $error("access granted from forbidden source area");
	user_default_a: assert property (
		$rose(req_valid) && !req_priv && tgt_any
			&& tgt_perm == AREA_PERM_RST[0] |-> req_denied)
		else $error("user access passed a closed area");
	reset_default_a: assert property (disable iff (1'b0)
		$fell(rst) |-> &at_dflt && !locked)
		else $error("defaults missing after reset");

endmodule : amag_guard

// ===== rtl/amag_pkg.sv
/*
 * constants and types of the area memory access guard: area count, access
 * operation and configuration field codes, permission bit layout and the
 * reset values of every area boundary and permission word.
 * assumes a 32-bit core address and that the core drives all inputs from
 * the same clock as the guard.
 */
package amag_pkg;

	// ------------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------------
	localparam int AREA_N = 4; // rom, ram, otp, spare
	localparam int AREA_IDX_W = 2; // index width for AREA_N areas
	localparam int ADDR_W = 32; // core address width

	// ------------------------------------------------------------------
	// codes
	// ------------------------------------------------------------------
	// operation that the core asks for
	typedef enum logic [1:0] {
		AMAG_OP_READ,
		AMAG_OP_WRITE,
		AMAG_OP_EXEC
	} amag_op_t;

	// which control word a configuration write targets
	typedef enum logic [1:0] {
		AMAG_F_BASE,
		AMAG_F_LIMIT,
		AMAG_F_PERM,
		AMAG_F_LOCK
	} amag_field_t;

	// ------------------------------------------------------------------
	// permission word layout
	// ------------------------------------------------------------------
	localparam int PERM_PRIV_LSB = 0; // priv read, write, exec bits 2:0
	localparam int PERM_USER_LSB = 3; // user read, write, exec bits 5:3
	localparam int PERM_SRC_LSB = 6; // one bit per allowed source area
	localparam int PERM_W = PERM_SRC_LSB + AREA_N;

	// ------------------------------------------------------------------
	// reset values: privileged may do anything, user nothing; the spare
	// area has base above limit so it matches no address until set up
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] AREA_BASE_RST [AREA_N] = '{
		32'h0000_0000, 32'h2000_0000, 32'h4000_0000, 32'hffff_ffff};
	localparam logic [ADDR_W-1:0] AREA_LIMIT_RST [AREA_N] = '{
		32'h0fff_ffff, 32'h2fff_ffff, 32'h4fff_ffff, 32'h0000_0000};
	localparam logic [PERM_W-1:0] AREA_PERM_RST [AREA_N] = '{
		10'h3c7, 10'h3c7, 10'h3c7, 10'h3c7};
	localparam logic LOCK_RST = 1'b0; // rules open to change after reset

endpackage : amag_pkg

// ===== verif/amag_mem_model.sv
/*
 * memory side model: counts the accesses that the guard passes on.
 * assumes the memory takes one access in each cycle where mem_valid is high.
 */
`timescale 1ns/1ns
module amag_mem_model (
	input wire logic mclk, // core clock
	input wire logic rst, // async reset, active high
	input wire logic mem_valid, // access forwarded by the guard
	output logic [31:0] hits // accesses that reached storage
);
	// ------------------------------------------------------------------
	// access counter
	// ------------------------------------------------------------------
	// a count is enough: any denied access that leaks shows as an extra hit
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hits <= 32'h0; // nothing reached memory yet
		end else if (mem_valid) begin
			hits <= hits + 32'h1;
		end
	end
endmodule : amag_mem_model

// ===== verif/test_area_memory_access_guard.sv
/*
 * self-checking bench of the guard: a bench copy of the area words works
 * out every decision, refusal and fault.
 * assumes the guard and the memory model share mclk and rst.
 */
`timescale 1ns/1ns
module test_area_memory_access_guard;
	import amag_pkg::*;
	// ------------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------------
	logic mclk = 1'b0, rst = 1'b1, cfg_valid = 1'b0, cfg_priv = 1'b0;
	logic [AREA_IDX_W-1:0] cfg_area = 2'h0;
	amag_field_t cfg_field = AMAG_F_BASE;
	logic [31:0] cfg_wdata = 32'h0, req_addr = 32'h0, req_src_addr = 32'h0;
	logic req_valid = 1'b0, req_priv = 1'b0;
	amag_op_t req_op = AMAG_OP_READ;
	logic cfg_refused, locked, mem_valid, req_denied, fault;
	logic [31:0] fault_addr, hits;
	amag_op_t fault_op;
	int fails = 0, samples_checked = 0;
	logic [31:0] seed = 32'hc90b8b16; // fixed start keeps runs repeatable
	// bench copy of the area words, updated by writes that land and reloaded with the defaults after reset
	logic [31:0] m_base [AREA_N] = AREA_BASE_RST;
	logic [31:0] m_limit [AREA_N] = AREA_LIMIT_RST;
	logic [PERM_W-1:0] m_perm [AREA_N] = AREA_PERM_RST;
	logic lk = 1'b0;
	always #2 mclk = ~mclk; // 250 MHz
	amag_guard dut (.mclk(mclk), .rst(rst), .cfg_valid(cfg_valid),
		.cfg_priv(cfg_priv), .cfg_area(cfg_area), .cfg_field(cfg_field),
		.cfg_wdata(cfg_wdata), .cfg_refused(cfg_refused), .locked(locked),
		.req_valid(req_valid), .req_priv(req_priv), .req_op(req_op),
		.req_addr(req_addr), .req_src_addr(req_src_addr),
		.mem_valid(mem_valid), .req_denied(req_denied), .fault(fault),
		.fault_addr(fault_addr), .fault_op(fault_op));
	amag_mem_model mem (.mclk(mclk), .rst(rst), .mem_valid(mem_valid),
		.hits(hits));
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr
	// lowest index wins where areas overlap; -1 when outside all
	function automatic int area_of(input logic [31:0] a);
		for (int i = 0; i < AREA_N; i++) begin
			if (m_base[i] <= a && a <= m_limit[i]) return i;
		end
		return -1;
	endfunction : area_of
	function automatic logic exp_deny(input logic p, input amag_op_t o,
		input logic [31:0] a, input logic [31:0] s);
		int t;
		logic s_in;
		logic s_ok;
		t = area_of(a);
		s_in = 1'b0;
		s_ok = 1'b0;
		if (t < 0) return 1'b0; // outside every area passes
		if (!m_perm[t][(p ? PERM_PRIV_LSB : PERM_USER_LSB) + int'(o)])
			return 1'b1;
		// a source in overlapping areas passes if any of them is listed
		for (int i = 0; i < AREA_N; i++) begin
			if (m_base[i] <= s && s <= m_limit[i]) begin
				s_in = 1'b1;
				s_ok = s_ok | m_perm[t][PERM_SRC_LSB + i];
			end
		end
		return s_in && !s_ok;
	endfunction : exp_deny
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// one access cycle, entered and left at a falling edge; req_valid
	// stays up so back-to-back accesses need no idle cycle
	task automatic access(input logic p, input amag_op_t o,
		input logic [31:0] a, input logic [31:0] s);
		logic d;
		logic [31:0] n;
		d = exp_deny(p, o, a, s);
		n = hits;
		cfg_valid = 1'b0;
		req_valid = 1'b1;
		req_priv = p;
		req_op = o;
		req_addr = a;
		req_src_addr = s;
		#1 check(req_denied, d);
		check(mem_valid, !d);
		@(negedge mclk);
		check(fault, d);
		if (d) check(fault_addr, a);
		if (d) check(fault_op, o);
		check(hits, n + !d);
	endtask : access
	task automatic cfg(input logic p, input logic [1:0] ar,
		input amag_field_t f, input logic [31:0] w);
		logic ok;
		ok = p && !lk;
		req_valid = 1'b0;
		cfg_valid = 1'b1;
		cfg_priv = p;
		cfg_area = ar;
		cfg_field = f;
		cfg_wdata = w;
		@(negedge mclk);
		check(cfg_refused, !ok);
		if (ok) begin
			case (f)
				AMAG_F_BASE: m_base[ar] = w;
				AMAG_F_LIMIT: m_limit[ar] = w;
				AMAG_F_PERM: m_perm[ar] = w[PERM_W-1:0];
				default: lk = w[0];
			endcase
		end
		check(locked, lk);
	endtask : cfg
	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		access(1'b0, AMAG_OP_READ, 32'h100, 32'h100);
		access(1'b1, AMAG_OP_EXEC, 32'h4000_0000, 32'h0);
		access(1'b0, AMAG_OP_WRITE, 32'hffff_ffff, 32'h0);
		cfg(1'b0, 2'h1, AMAG_F_PERM, 32'h3ff);
		access(1'b0, AMAG_OP_WRITE, 32'h2000_0010, 32'h0);
		cfg(1'b1, 2'h1, AMAG_F_PERM, 32'h0ff);
		access(1'b0, AMAG_OP_WRITE, 32'h2fff_ffff, 32'h10);
		access(1'b0, AMAG_OP_READ, 32'h2000_0000, 32'h4000_0000);
		for (int i = 0; i < 400; i++) begin
			seed = lfsr(seed);
			if (seed[2:0] == 3'h0)
				cfg(seed[3], seed[5:4], amag_field_t'(seed[7:6] % 3),
					{seed[7:0], seed[31:8]} & 32'h4fff_ffff);
			else
				access(seed[3], amag_op_t'(seed[5:4] % 3),
					seed & 32'h4fff_ffff,
					{seed[15:0], seed[31:16]} & 32'h4fff_ffff);
		end
		cfg(1'b1, 2'h0, AMAG_F_LOCK, 32'h1);
		cfg(1'b1, 2'h0, AMAG_F_PERM, 32'h3ff);
		access(1'b0, AMAG_OP_READ, 32'h0, 32'h0);
		rst = 1'b1;
		req_valid = 1'b0;
		@(negedge mclk);
		rst = 1'b0;
		m_base = AREA_BASE_RST;
		m_limit = AREA_LIMIT_RST;
		m_perm = AREA_PERM_RST;
		lk = 1'b0;
		check(locked, 1'b0);
		access(1'b1, AMAG_OP_WRITE, 32'h2000_0000, 32'h0);
		report_and_stop();
	end
endmodule : test_area_memory_access_guard
